/* esa_checker.sv */
// Concurrent checks on the link between the eye-scan receiver end and its controller.
// Assumes one clock and one asynchronous active-high reset shared by both ends.
`timescale 1ns/1ns
`default_nettype none
module esa_checker (
	input wire logic                                              i_clk,
	input wire logic                                              i_rst,
	input wire logic                                              receiver_enable,
	input wire logic                                              scan_run,
	input wire logic                                              counter_clear,
	input wire logic [esa_pkg::LEN_W-1:0]                         scan_length_setting,
	input wire logic [esa_pkg::EQF_W-1:0]                         equalizer_function_select,
	input wire logic                                              equalizer_freeze,
	input wire logic [esa_pkg::NUM_LANES-1:0]                     scan_complete_flag,
	input wire logic [esa_pkg::NUM_LANES-1:0][esa_pkg::CNT_W-1:0] mismatch_count,
	input wire logic [esa_pkg::EQLVL_W-1:0]                       equalizer_level_readback,
	input wire logic                                              over_equalized_flag,
	input wire logic                                              under_equalized_flag
);
	import esa_pkg::*;
	// ==========================================================================
	// Cycle counters
	// Two extra cycles allow for the register stage on each side of the link.
	localparam int FRZ_LIM = FREEZE_CYC + 2;
	int run_q;
	int frz_q;
	int unf_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			run_q <= 0;
		else
			run_q <= scan_run ? run_q + 1 : 0;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			frz_q <= 0;
		else
			frz_q <= !equalizer_freeze ? 0 : (frz_q < FRZ_LIM) ? frz_q + 1 : frz_q;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		// Cleared only once the freeze has surely taken effect, since old flags may stand through the delay.
		if (i_rst)
			unf_q <= 0;
		else if (frz_q >= FRZ_LIM)
			unf_q <= 0;
		else if (!equalizer_freeze && equalizer_function_select >= EQF_PRE && unf_q < CURSOR_CYC)
			unf_q <= unf_q + 1;
	end

	// ==========================================================================
	// Properties
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_clear_held;
		counter_clear [*2];
	endsequence
	sequence s_idle_pair;
		(!scan_run && !counter_clear) [*2];
	endsequence
	sequence s_rx_off;
		(!receiver_enable) [*3];
	endsequence

	a_clear_zeroes_count: assert property (s_clear_held |-> mismatch_count == '0)
		else $error("Count not zero after clear.");
	a_count_holds_idle: assert property (s_idle_pair |=> $stable(mismatch_count))
		else $error("Count moved with no run.");
	a_run_low_done: assert property (!scan_run |=> scan_complete_flag == '0)
		else $error("Complete flag without run.");
	a_done_holds: assert property (scan_run && scan_complete_flag[0] ##1 scan_run |-> scan_complete_flag[0])
		else $error("Complete flag dropped during run.");
	a_no_early_done: assert property ((scan_complete_flag & ~$past(scan_complete_flag)) != '0
		|-> run_q >= ((32'd64 << scan_length_setting) - 1) * 20) else $error("Scan finished too early.");
	a_rx_off_quiet: assert property (s_rx_off ##0 scan_complete_flag == '0 |=> scan_complete_flag == '0)
		else $error("Scan finished with receiver off.");
	a_freeze_flags_low: assert property (frz_q >= FRZ_LIM |-> !over_equalized_flag && !under_equalized_flag)
		else $error("Equalizer flag high while frozen.");
	a_freeze_level_hold: assert property (frz_q >= FRZ_LIM && equalizer_freeze |=> $stable(equalizer_level_readback))
		else $error("Level moved while frozen.");
	a_cursor_level_lock: assert property (equalizer_function_select >= EQF_PRE |=> $stable(equalizer_level_readback))
		else $error("Level moved during cursor analysis.");
	a_cursor_quiet: assert property (!equalizer_freeze && equalizer_function_select >= EQF_PRE && unf_q < CURSOR_CYC
		|-> !over_equalized_flag && !under_equalized_flag) else $error("Cursor result before window end.");
endmodule
`default_nettype wire

/* esa_ctl.sv */
// Controller end: software reaches the diagnostic controls over classic Wishbone.
// Assumes one clock shared with the receiver end.
`timescale 1ns/1ns
`default_nettype none
module esa_ctl (
	input  wire logic                        i_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_wb_cyc,
	input  wire logic                        i_wb_stb,
	input  wire logic                        i_wb_we,
	input  wire logic [esa_pkg::ADDR_W-1:0]  i_wb_adr,
	input  wire logic [esa_pkg::DATA_W-1:0]  i_wb_dat,
	input  wire logic [3:0]                  i_wb_sel,
	output logic [esa_pkg::DATA_W-1:0]       o_wb_dat,
	output logic                             o_wb_ack,
	output logic                             o_irq,
	esa_if.ctl                               link
);
	import esa_pkg::*;

	logic [DATA_W-1:0]    ctrl_q;
	logic [DATA_W-1:0]    scan_q;
	logic [IRQ_W-1:0]     ist_q;
	logic [IRQ_W-1:0]     imk_q;
	logic                 ack_q;
	logic [DATA_W-1:0]    rd_q;
	logic                 wr;
	logic [DATA_W-1:0]    wmask;
	logic                 done_all;
	logic                 done_q;
	logic                 over_q;
	logic                 under_q;

	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] m,
	                                           input logic [DATA_W-1:0] d);
		merge = (old & ~m) | (d & m);
	endfunction

	assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
	assign wr    = i_wb_cyc && i_wb_stb && i_wb_we && !ack_q;

	// ==========================================================================
	// Registers. Settings are held steady by software while a run is active.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= '0;
			scan_q <= '0;
			imk_q  <= '0;
		end else if (wr) begin
			case (i_wb_adr)
				REG_CTRL:   ctrl_q <= merge(ctrl_q, wmask, i_wb_dat);
				REG_SCAN:   scan_q <= merge(scan_q, wmask, i_wb_dat);
				REG_IRQ_MK: imk_q  <= i_wb_dat[IRQ_W-1:0];
				default:    ;
			endcase
		end
	end

	assign done_all = &(link.scan_complete_flag | ~{NUM_LANES{1'b1}}) && link.scan_complete_flag != '0;

	// Sticky events: a hardware set in the same cycle as a clear wins.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ist_q   <= '0;
			done_q  <= 1'b0;
			over_q  <= 1'b0;
			under_q <= 1'b0;
		end else begin
			done_q  <= done_all;
			over_q  <= link.over_equalized_flag;
			under_q <= link.under_equalized_flag;
			ist_q   <= (ist_q & ~((wr && i_wb_adr == REG_IRQ_ST) ? i_wb_dat[IRQ_W-1:0] : '0))
			         | {link.under_equalized_flag && !under_q, link.over_equalized_flag && !over_q,
			            done_all && !done_q};
		end
	end
	assign o_irq = |(ist_q & imk_q);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack_q <= 1'b0;
			rd_q  <= '0;
		end else begin
			ack_q <= i_wb_cyc && i_wb_stb && !ack_q;
			case (i_wb_adr)
				REG_CTRL:   rd_q <= ctrl_q;
				REG_SCAN:   rd_q <= scan_q;
				REG_EQ:     rd_q <= DATA_W'({link.under_equalized_flag, link.over_equalized_flag,
				                             link.equalizer_level_readback});
				REG_STAT:   rd_q <= DATA_W'(link.scan_complete_flag);
				REG_COUNT0: rd_q <= link.mismatch_count[0];
				REG_COUNT1: rd_q <= link.mismatch_count[1];
				REG_BOUND:  rd_q <= DATA_W'({link.boundary_offset_readback[1], link.boundary_offset_readback[0]});
				REG_IRQ_ST: rd_q <= DATA_W'(ist_q);
				REG_IRQ_MK: rd_q <= DATA_W'(imk_q);
				default:    rd_q <= '0;
			endcase
		end
	end
	assign o_wb_ack = ack_q;
	assign o_wb_dat = rd_q;

	assign link.receiver_enable           = ctrl_q[CTRL_RXEN];
	assign link.scan_run                  = ctrl_q[CTRL_RUN];
	assign link.counter_clear             = ctrl_q[CTRL_CLR];
	assign link.equalizer_freeze          = ctrl_q[CTRL_FRZ];
	assign link.equalizer_function_select = ctrl_q[CTRL_EQF +: EQF_W];
	assign link.eye_scan_mode_select      = scan_q[SCAN_MODE +: MODE_W];
	assign link.scan_voltage_offset       = scan_q[SCAN_VOFS +: VOFS_W];
	assign link.scan_phase_offset         = scan_q[SCAN_POFS +: POFS_W];
	assign link.decimation_phase_select   = scan_q[SCAN_BSEL +: BITSEL_W];
	assign link.scan_length_setting       = scan_q[SCAN_LEN +: LEN_W];
endmodule
`default_nettype wire

/* esa_dev.sv */
// Receiver-side eye-scan and equalizer-analysis logic, one instance for all lanes.
// Assumes the lane data arrives as one bit per lane per clock, synchronous to i_clk.
`timescale 1ns/1ns
`default_nettype none
module esa_dev (
	input  wire logic                         i_clk,
	input  wire logic                         i_rst,
	input  wire logic [esa_pkg::NUM_LANES-1:0] i_lane_bit,
	input  wire logic [esa_pkg::NUM_LANES-1:0] i_lane_active,
	input  wire logic [esa_pkg::NUM_LANES-1:0] i_lane_ref,
	esa_if.dev                                 bus
);
	import esa_pkg::*;

	// ==========================================================================
	// Eye sampler model: the offset sampler reads the bit with the voltage
	// offset compared against unsigned thresholds built from the phase offset, {2'h2, p} for a one bit and {2'h1, p} for a zero bit.
	function automatic logic offs_sample(input logic b, input logic [VOFS_W-1:0] v,
	                                     input logic [POFS_W-1:0] p);
		logic [VOFS_W-1:0] thr;
		thr = {2'h2, p};
		offs_sample = b ? (v < thr) : (v >= thr) ? 1'b0 : 1'b0;
		if (b && v >= thr)
			offs_sample = 1'b0;
		if (!b && v < {2'h1, p})
			offs_sample = 1'b0;
		else if (!b)
			offs_sample = 1'b1;
	endfunction

	function automatic logic [CNT_W-1:0] len_samples(input logic [LEN_W-1:0] l);
		len_samples = CNT_W'(64) << l;
	endfunction

	logic                                 auto_mode;
	logic [BITSEL_W-1:0]                  decim_q;
	logic                                 take;
	logic                                 run_d1_q;
	logic [CNT_W-1:0]                     smp_q;
	logic [NUM_LANES-1:0]                 done_q;
	logic [NUM_LANES-1:0]                 lane_sel_q;
	logic [NUM_LANES-1:0][CNT_W-1:0]      cnt_q;
	logic [NUM_LANES-1:0][VOFS_W-1:0]     vofs_q;
	logic [NUM_LANES-1:0][VOFS_W-1:0]     bnd_q;

	assign auto_mode = (bus.eye_scan_mode_select >= MODE_AUTO_FIRST);
	assign take      = bus.receiver_enable && bus.scan_run && (decim_q == bus.decimation_phase_select);

	// ==========================================================================
	// Decimate-by-20 phase counter.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			decim_q <= '0;
		else if (decim_q == DECIM_LAST)
			decim_q <= '0;
		else
			decim_q <= decim_q + 1'b1;
	end

	// ==========================================================================
	// Run sequencing shared by all lanes, so every enabled lane starts together.
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			run_d1_q   <= 1'b0;
			smp_q      <= '0;
			lane_sel_q <= '0;
		end else begin
			run_d1_q <= bus.scan_run;
			if (bus.scan_run && !run_d1_q) begin
				smp_q      <= '0;
				lane_sel_q <= i_lane_active;
			end else if (take && smp_q != len_samples(bus.scan_length_setting))
				smp_q <= smp_q + 1'b1;
		end
	end

	// Per-lane counting and boundary search.
	for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
		logic hit;
		logic got;
		assign got = offs_sample(i_lane_bit[g], auto_mode ? vofs_q[g] : bus.scan_voltage_offset,
		                         bus.scan_phase_offset);
		assign hit = (bus.eye_scan_mode_select == MODE_COUNT_MATCH) ? (got == i_lane_ref[g])
		                                                           : (got != i_lane_ref[g]);

		always_ff @(posedge i_clk or posedge i_rst) begin
			if (i_rst) begin
				done_q[g] <= 1'b0;
				cnt_q[g]  <= '0;
				vofs_q[g] <= '0;
				bnd_q[g]  <= '0;
			end else begin
				if (!bus.scan_run)
					done_q[g] <= 1'b0;
				else if (lane_sel_q[g] && run_d1_q && smp_q == len_samples(bus.scan_length_setting))
					done_q[g] <= 1'b1;
				if (bus.counter_clear)
					cnt_q[g] <= '0;
				else if (take && lane_sel_q[g] && run_d1_q && !done_q[g] && !auto_mode && hit)
					cnt_q[g] <= cnt_q[g] + 1'b1;
				if (bus.scan_run && !run_d1_q)
					vofs_q[g] <= (bus.eye_scan_mode_select == MODE_OUTER) ? VOFS_MAX : '0;
				else if (take && lane_sel_q[g] && auto_mode && !done_q[g]) begin
					// Inner: highest offset still reading zero on a lane whose reference is one.
					if (bus.eye_scan_mode_select == MODE_INNER && !got && i_lane_ref[g]) begin
						bnd_q[g]  <= vofs_q[g];
						vofs_q[g] <= vofs_q[g] + 1'b1;
					end else if (bus.eye_scan_mode_select == MODE_OUTER && got != i_lane_ref[g]) begin
						bnd_q[g]  <= vofs_q[g];
						vofs_q[g] <= vofs_q[g] - 1'b1;
					end else if (bus.eye_scan_mode_select == MODE_AVERAGE) begin
						bnd_q[g]  <= VOFS_W'((VOFS_W+1)'(bnd_q[g]) + (VOFS_W+1)'(vofs_q[g]) >> 1);
						vofs_q[g] <= vofs_q[g] + 1'b1;
					end
				end
			end
		end
	end

	assign bus.scan_complete_flag       = done_q;
	assign bus.mismatch_count           = cnt_q;
	assign bus.boundary_offset_readback = bnd_q;

	// ==========================================================================
	// Equalizer. Adaptation nudges the level toward data edges once per period;
	// cursor analysis integrates early and late error for a fixed window.
	logic [EQLVL_W-1:0] lvl_q;
	logic               frz_q;
	logic [5:0]         frz_dly_q;
	logic [7:0]         adp_q;
	logic [17:0]        win_q;
	logic signed [19:0] acc_q;
	logic               over_q;
	logic               under_q;
	logic               cursor;

	assign cursor = (bus.equalizer_function_select == EQF_PRE) || (bus.equalizer_function_select == EQF_POST);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			frz_q     <= 1'b0;
			frz_dly_q <= '0;
		end else if (bus.equalizer_freeze != frz_q) begin
			if (frz_dly_q == 6'(FREEZE_CYC - 1)) begin
				frz_q     <= bus.equalizer_freeze;
				frz_dly_q <= '0;
			end else
				frz_dly_q <= frz_dly_q + 1'b1;
		end else
			frz_dly_q <= '0;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lvl_q <= EQLVL_RST;
			adp_q <= '0;
		end else if (bus.receiver_enable && !frz_q && bus.equalizer_function_select == EQF_ADAPT) begin
			adp_q <= adp_q + 1'b1;
			if (adp_q == 8'(ADAPT_PERIOD - 1)) begin
				adp_q <= '0;
				if (i_lane_bit[0] != i_lane_ref[0] && lvl_q != '1)
					lvl_q <= lvl_q + 1'b1;
				else if (i_lane_bit[0] == i_lane_ref[0] && lvl_q != '0)
					lvl_q <= lvl_q - 1'b1;
			end
		end
	end
	assign bus.equalizer_level_readback = lvl_q;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			win_q   <= '0;
			acc_q   <= '0;
			over_q  <= 1'b0;
			under_q <= 1'b0;
		end else if (frz_q) begin
			win_q   <= '0;
			acc_q   <= '0;
			over_q  <= 1'b0;
			under_q <= 1'b0;
		end else if (cursor && bus.receiver_enable && win_q != 18'(CURSOR_CYC)) begin
			win_q <= win_q + 1'b1;
			if (i_lane_bit[0] != i_lane_ref[0])
				acc_q <= (bus.equalizer_function_select == EQF_PRE) ? acc_q + 20'sd1 : acc_q - 20'sd1;
			if (win_q == 18'(CURSOR_CYC - 1)) begin
				over_q  <= (acc_q > 0);
				under_q <= (acc_q < 0);
			end
		end
	end
	assign bus.over_equalized_flag  = over_q;
	assign bus.under_equalized_flag = under_q;
endmodule
`default_nettype wire

/* esa_if.sv */
// Interface joining the diagnostic receiver end and its controller.
// Assumes both ends share one clock and one reset.
`timescale 1ns/1ns
`default_nettype none
interface esa_if;
	import esa_pkg::*;
	logic                                receiver_enable;
	logic                                scan_run;
	logic                                counter_clear;
	logic [MODE_W-1:0]                   eye_scan_mode_select;
	logic [VOFS_W-1:0]                   scan_voltage_offset;
	logic [POFS_W-1:0]                   scan_phase_offset;
	logic [BITSEL_W-1:0]                 decimation_phase_select;
	logic [LEN_W-1:0]                    scan_length_setting;
	logic [EQF_W-1:0]                    equalizer_function_select;
	logic                                equalizer_freeze;
	logic [NUM_LANES-1:0]                scan_complete_flag;
	logic [NUM_LANES-1:0][CNT_W-1:0]     mismatch_count;
	logic [NUM_LANES-1:0][VOFS_W-1:0]    boundary_offset_readback;
	logic [EQLVL_W-1:0]                  equalizer_level_readback;
	logic                                over_equalized_flag;
	logic                                under_equalized_flag;

	modport dev (
		input  receiver_enable, scan_run, counter_clear, eye_scan_mode_select, scan_voltage_offset,
		       scan_phase_offset, decimation_phase_select, scan_length_setting,
		       equalizer_function_select, equalizer_freeze,
		output scan_complete_flag, mismatch_count, boundary_offset_readback,
		       equalizer_level_readback, over_equalized_flag, under_equalized_flag
	);
	modport ctl (
		output receiver_enable, scan_run, counter_clear, eye_scan_mode_select, scan_voltage_offset,
		       scan_phase_offset, decimation_phase_select, scan_length_setting,
		       equalizer_function_select, equalizer_freeze,
		input  scan_complete_flag, mismatch_count, boundary_offset_readback,
		       equalizer_level_readback, over_equalized_flag, under_equalized_flag
	);
endinterface
`default_nettype wire

/* esa_pkg.sv */
// Package for the lane eye-scan and equalizer-analysis block.
// Shared by the receiver-side diagnostic end and the controller end.
package esa_pkg;
	// ==========================================================================
	// Geometry
	localparam int NUM_LANES   = 2;
	localparam int MODE_W      = 4;
	localparam int VOFS_W      = 8;
	localparam int POFS_W      = 6;
	localparam int BITSEL_W    = 5;
	localparam int LEN_W       = 4;
	localparam int CNT_W       = 32;
	localparam int EQF_W       = 2;
	localparam int EQLVL_W     = 5;
	localparam int ADDR_W      = 8;
	localparam int DATA_W      = 32;

	// ==========================================================================
	// Scan modes and decimation
	localparam logic [MODE_W-1:0] MODE_COUNT_MATCH = 4'h1;
	localparam logic [MODE_W-1:0] MODE_AUTO_FIRST  = 4'h8;
	localparam logic [MODE_W-1:0] MODE_INNER       = 4'h8;
	localparam logic [MODE_W-1:0] MODE_OUTER       = 4'h9;
	localparam logic [MODE_W-1:0] MODE_AVERAGE     = 4'hA;
	localparam logic [BITSEL_W-1:0] DECIM_LAST     = 5'h13;
	localparam logic [VOFS_W-1:0]   VOFS_MAX       = 8'hFF;

	// ==========================================================================
	// Equalizer functions
	localparam logic [EQF_W-1:0] EQF_ADAPT = 2'h1;
	localparam logic [EQF_W-1:0] EQF_PRE   = 2'h2;
	localparam logic [EQF_W-1:0] EQF_POST  = 2'h3;
	localparam logic [EQLVL_W-1:0] EQLVL_RST = 5'h10;

	// ==========================================================================
	// Timing: one unit interval is one lane clock cycle here.
	localparam int FREEZE_UI       = 48;
	localparam int CURSOR_UI       = 150000;
	localparam int FREEZE_CYC      = (FREEZE_UI < 1) ? 1 : FREEZE_UI;
	localparam int CURSOR_CYC      = (CURSOR_UI < 1) ? 1 : CURSOR_UI;
	localparam int ADAPT_PERIOD    = 64;

	// ==========================================================================
	// Controller register map (Wishbone byte addresses)
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SCAN   = 8'h04;
	localparam logic [ADDR_W-1:0] REG_EQ     = 8'h08;
	localparam logic [ADDR_W-1:0] REG_STAT   = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_COUNT0 = 8'h10;
	localparam logic [ADDR_W-1:0] REG_COUNT1 = 8'h14;
	localparam logic [ADDR_W-1:0] REG_BOUND  = 8'h18;
	localparam logic [ADDR_W-1:0] REG_IRQ_ST = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_IRQ_MK = 8'h20;
	// REG_CTRL fields
	localparam int CTRL_RXEN = 0;
	localparam int CTRL_RUN  = 1;
	localparam int CTRL_CLR  = 2;
	localparam int CTRL_FRZ  = 3;
	localparam int CTRL_EQF  = 4;
	// REG_SCAN fields
	localparam int SCAN_MODE = 0;
	localparam int SCAN_VOFS = 4;
	localparam int SCAN_POFS = 12;
	localparam int SCAN_BSEL = 18;
	localparam int SCAN_LEN  = 23;
	// IRQ bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_OVER  = 1;
	localparam int IRQ_UNDER = 2;
	localparam int IRQ_W     = 3;
endpackage

/* test_serdes_eye_scan_eq_analysis.sv */
// Testbench: both ends joined by the interface, driven over Wishbone.
// Assumes esa_pkg, esa_if, esa_dev, esa_ctl and esa_checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_serdes_eye_scan_eq_analysis;
	import esa_pkg::*;
	logic                 i_clk = 1'b0;
	logic                 i_rst = 1'b1;
	logic                 cyc = 1'b0;
	logic                 we = 1'b0;
	logic [ADDR_W-1:0]    adr = '0;
	logic [DATA_W-1:0]    wdat = '0;
	logic [DATA_W-1:0]    rdat;
	logic                 ack;
	logic                 irq;
	logic [NUM_LANES-1:0] act = 2'h3;
	logic [DATA_W-1:0]    q;
	logic [DATA_W-1:0]    lvl;
	int                   n_fail = 0;
	int                   compares = 0;
	int                   ticks = 0;

	esa_if link();
	// Lane 0 always differs from its reference, lane 1 always matches.
	esa_dev u_esa_dev (.i_clk(i_clk), .i_rst(i_rst), .i_lane_bit(2'h1), .i_lane_active(act), .i_lane_ref(2'h0),
		.bus(link));
	esa_ctl u_esa_ctl (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_dat(wdat), .i_wb_sel(4'hF), .o_wb_dat(rdat), .o_wb_ack(ack), .o_irq(irq), .link(link));
	esa_checker u_chk (.i_clk(i_clk), .i_rst(i_rst), .receiver_enable(link.receiver_enable),
		.scan_run(link.scan_run), .counter_clear(link.counter_clear), .scan_length_setting(link.scan_length_setting),
		.equalizer_function_select(link.equalizer_function_select), .equalizer_freeze(link.equalizer_freeze),
		.scan_complete_flag(link.scan_complete_flag), .mismatch_count(link.mismatch_count),
		.equalizer_level_readback(link.equalizer_level_readback), .over_equalized_flag(link.over_equalized_flag),
		.under_equalized_flag(link.under_equalized_flag));

	// ==========================================================================
	// Clock, timeout and tasks
	initial begin
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		ticks <= ticks + 1;
		if (ticks == 100000) begin
			n_fail++;
			results();
		end
	end
	task automatic results();
		if (n_fail == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		if (n >= 20) begin
			n_fail++;
			$display("[FAIL] %0t no bus answer", $time);
		end
		@(posedge i_clk);
	endtask
	task automatic scan(input int mode, input int len, input int bsel, input bit clr, input logic [1:0] exp);
		int n;
		// An offset just below the zero-bit threshold keeps lane 1 reading its zeros as zeros.
		wb(1, REG_SCAN, 32'((len << SCAN_LEN) | (bsel << SCAN_BSEL) | (32'h3F << SCAN_VOFS) | mode));
		if (clr) begin
			wb(1, REG_CTRL, 32'h5);
			wb(1, REG_CTRL, 32'h1);
		end
		wb(1, REG_CTRL, 32'h3);
		n = 0;
		do begin
			wb(0, REG_STAT, 0);
			n++;
		end while (q[1:0] !== exp && n < 9000);
		chk(q, 32'(exp));
		chk(32'(n * 3 >= ((64 << len) - 1) * 20), 1);
	endtask

	// ==========================================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		wb(0, REG_EQ, 0);
		chk(q, 32'(EQLVL_RST));
		wb(1, 8'h3C, 32'hFFFF);
		wb(0, 8'h3C, 0);
		chk(q, 0);
		wb(1, REG_CTRL, 32'h2);
		repeat (3000) @(posedge i_clk);
		wb(0, REG_STAT, 0);
		chk(q, 0);
		wb(1, REG_CTRL, 32'h0);
		for (int m = 0; m < 8; m++) begin
			scan(m, m % 2, 19 - m, 1, 2'h3);
			wb(0, REG_COUNT0, 0);
			chk(q, (m == 1) ? 0 : (64 << (m % 2)));
			wb(0, REG_COUNT1, 0);
			chk(q, (m == 1) ? (64 << (m % 2)) : 0);
			wb(1, REG_CTRL, 32'h1);
			wb(0, REG_STAT, 0);
			chk(q, 0);
		end
		scan(0, 0, 0, 0, 2'h3);
		wb(0, REG_COUNT0, 0);
		chk(q, 192);
		wb(1, REG_CTRL, 32'h5);
		wb(1, REG_CTRL, 32'h1);
		wb(0, REG_COUNT0, 0);
		chk(q, 0);
		wb(0, REG_IRQ_ST, 0);
		chk(q & 32'h1, 1);
		chk({31'h0, irq}, 0);
		wb(1, REG_IRQ_MK, 32'h1);
		chk({31'h0, irq}, 1);
		wb(1, REG_IRQ_ST, 32'h1);
		chk({31'h0, irq}, 0);
		for (int m = 8; m < 11; m++) begin
			scan(m, 0, 0, 1, 2'h3);
			// Outer search on lane 1 steps down from the top once per sample, 64 samples in all.
			if (m == 9) begin
				wb(0, REG_BOUND, 0);
				chk(q, 32'hC000);
			end
			wb(1, REG_CTRL, 32'h1);
		end
		act <= 2'h1;
		scan(0, 0, 5, 1, 2'h1);
		repeat (200) @(posedge i_clk);
		wb(0, REG_STAT, 0);
		chk(q, 1);
		wb(1, REG_CTRL, 32'h1);
		act <= 2'h3;
		wb(1, REG_CTRL, 32'h11);
		repeat (300) @(posedge i_clk);
		wb(1, REG_CTRL, 32'h19);
		repeat (FREEZE_CYC + 10) @(posedge i_clk);
		wb(0, REG_EQ, 0);
		lvl = q;
		chk(q & 32'h60, 0);
		wb(1, REG_CTRL, 32'h29);
		wb(1, REG_CTRL, 32'h21);
		repeat (3000) @(posedge i_clk);
		wb(0, REG_EQ, 0);
		chk(q, lvl);
		wb(1, REG_CTRL, 32'h29);
		repeat (60) @(posedge i_clk);
		wb(1, REG_CTRL, 32'h19);
		wb(1, REG_CTRL, 32'h11);
		repeat (FREEZE_CYC + 200) @(posedge i_clk);
		wb(0, REG_EQ, 0);
		chk(32'(q[4:0] > lvl[4:0]), 1);
		results();
	end
endmodule
`default_nettype wire
